// ==== hps_pkg.sv ====
package hps_pkg;
	// ----------------------------------------------------------------
	// command latch bit positions
	// ----------------------------------------------------------------
	localparam int unsigned CMD_LED_ON = 1;
	localparam int unsigned CMD_ALL_OFF = 2;
	localparam int unsigned CMD_RST_ASSERT = 3;
	localparam int unsigned CMD_IGN_POS12 = 4;
	localparam int unsigned CMD_IGN_NEG12 = 5;
	// no override after power arrives
	localparam logic [7:0] CMD_RESET = 8'h00;

	// ----------------------------------------------------------------
	// serial target
	// ----------------------------------------------------------------
	localparam logic [1:0] ADDR_TOP = 2'h3;
	localparam logic [4:0] ADDR_SEL_LOW = 5'h08;
	localparam logic [4:0] ADDR_SEL_HIGH = 5'h17;
	localparam logic [3:0] BIT_LAST = 4'h7;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned FILT_NS = 35000;
	localparam int unsigned FILT_CYC = FILT_NS * CLK_MHZ / 1000;
	localparam logic [11:0] FILT_CNT = 12'(FILT_CYC);

	// supply indices and fault codes
	localparam int unsigned NSUP = 4;
	localparam logic [1:0] SUP_3V = 2'h0;
	localparam logic [1:0] SUP_5V = 2'h1;
	localparam logic [1:0] SUP_12V = 2'h2;
	localparam logic [1:0] SUP_NEG = 2'h3;
	// reported code {bit1, bit0}; 5V and 12V are not the index order
	localparam logic [1:0] CODE_3V = 2'h0;
	localparam logic [1:0] CODE_5V = 2'h2;
	localparam logic [1:0] CODE_12V = 2'h1;
	localparam logic [1:0] CODE_NEG = 2'h3;

	typedef enum logic [1:0]
	{
		SEQ_OFF = 2'h0,
		SEQ_RAMP = 2'h1,
		SEQ_ON = 2'h3,
		SEQ_DOWN = 2'h2
	} hps_seq_e;
endpackage : hps_pkg

// ==== hps_sync.sv ====
`timescale 1ns/1ns
// two-flop synchroniser for pin inputs
module hps_sync #(
	parameter int unsigned W = 1
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [W-1:0] D,
	output logic [W-1:0] Q
);
	typedef struct packed
	{
		logic [W-1:0] s1_r;
		logic [W-1:0] s2_r;
	} hps_sync_s;

	hps_sync_s st_r;
	hps_sync_s st_nxt;

	// first stage feeds only the second
	always_comb
	begin
		st_nxt.s1_r = D;
		st_nxt.s2_r = st_r.s1_r;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign Q = st_r.s2_r;
endmodule : hps_sync

// ==== hps_filt.sv ====
`timescale 1ns/1ns
// overcurrent persistence filter, one per supply
module hps_filt (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic OC,
	input wire logic CLR,
	output logic TRIP
);
	typedef struct packed
	{
		logic [11:0] cnt_r;
		logic trip_r;
	} hps_filt_s;

	hps_filt_s st_r;
	hps_filt_s st_nxt;

	// count persisting condition, drop on any gap; trip holds till cleared
	always_comb
	begin
		st_nxt = st_r;
		if (!OC)
			st_nxt.cnt_r = '0;
		else if (st_r.cnt_r != hps_pkg::FILT_CNT)
			st_nxt.cnt_r = st_r.cnt_r + 12'h001;
		if (CLR)
			st_nxt.trip_r = 1'b0;
		else if (OC && st_r.cnt_r == hps_pkg::FILT_CNT)
			st_nxt.trip_r = 1'b1;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign TRIP = st_r.trip_r;
endmodule : hps_filt

// ==== hps_top.sv ====
`timescale 1ns/1ns
// How it works
// - command bits ignore_pos12 and ignore_neg12 mask faults of the +12V and -12V supplies.
// - once supplies are good local reset follows incoming reset, and rst_assert_cmd forces it low.
// - a high board select or all_off_cmd starts power-down and opens all four switches.
// - led_on_cmd lights the status LED regardless of the local reset.
// - the status byte is code2, code1, good, local reset, incoming reset, code bit1, bit0, fault.
// - with fault low the two code bits name the faulting supply; with fault high they mean nothing.
// - the serial target answers only send byte and receive byte transactions.
// - one address-select input picks the target address out of the two allowed.
// - power-up starts on a falling board select or a serial power cycle.
// - current-limit faults are blanked until the timer threshold is crossed.
// - the board-board_ok_n output goes low only when every supply is good.
// - after power-down completes the status LED lights for removal.
// - before power-up local reset is held, LED lit and switches off.
// - the command latch resets to no override when power arrives.
// - a serial command aborts the connection sequence at once.
// - each supply's overcurrent trips the breaker after persisting 35 us.
module hps_top (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic ADDR_SEL,
	input wire logic BOARD_SELECT_N,
	input wire logic INCOMING_RST_PIN,
	input wire logic BOARD_POWER_CODE1_N,
	input wire logic BOARD_POWER_CODE2_N,
	input wire logic [3:0] SUPPLY_GOOD,
	input wire logic [3:0] OVER_CURRENT,
	input wire logic TIMER_DONE,
	output logic [3:0] SWITCH_ON,
	output logic LOCAL_RST_PIN_N,
	output logic STATUS_LED,
	output logic BOARD_OK_N,
	output logic FAULT_N,
	output logic SUPPLY_CODE_BIT0,
	output logic SUPPLY_CODE_BIT1
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int unsigned NPIN = 16;
	logic [NPIN-1:0] pins_s;
	logic scl_s, sda_s, asel_s, bsel_s, rstin_s, pc1_s, pc2_s, tmr_s;
	logic [3:0] good_s, oc_s;

	hps_sync #(.W(NPIN)) u_sync (
		.CLK(CLK),
		.RST_N(RST_N),
		.D({SCL, SDA_IN, ADDR_SEL, BOARD_SELECT_N, INCOMING_RST_PIN,
			BOARD_POWER_CODE1_N, BOARD_POWER_CODE2_N, TIMER_DONE,
			SUPPLY_GOOD, OVER_CURRENT}),
		.Q(pins_s)
	);
	assign {scl_s, sda_s, asel_s, bsel_s, rstin_s, pc1_s, pc2_s, tmr_s,
		good_s, oc_s} = pins_s;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		I2C_IDLE = 3'h0,
		I2C_ADDR = 3'h1,
		I2C_AACK = 3'h3,
		I2C_WDAT = 3'h2,
		I2C_DACK = 3'h6,
		I2C_RDAT = 3'h7,
		I2C_RACK = 3'h5,
		I2C_SKIP = 3'h4
	} hps_i2c_e;

	typedef struct packed
	{
		logic scl_d_r;
		logic sda_d_r;
		logic bsel_d_r;
		hps_i2c_e i2c_r;
		logic [3:0] bit_r;
		logic [7:0] sh_r;
		logic rw_r;
		logic sda_oe_r;
		logic [7:0] cmd_r;
		logic cyc_r;
		hps_pkg::hps_seq_e seq_r;
		logic [1:0] code_r;
		logic fault_r;
		logic lrst_r;
		logic ok_r;
		logic led_r;
	} hps_top_s;

	hps_top_s st_r;
	hps_top_s st_nxt;

	logic [3:0] trip;
	logic [3:0] oc_en;
	logic clr_trip;
	logic [3:0] ign;
	logic [7:0] status;
	logic [6:0] my_addr;

	// ----------------------------------------------------------------
	// breaker filters, blanked until the timer threshold
	// ----------------------------------------------------------------
	assign clr_trip = st_r.seq_r == hps_pkg::SEQ_OFF;
	// an ignored supply must not leave a latched trip behind for later
	assign ign[hps_pkg::SUP_3V] = 1'b0;
	assign ign[hps_pkg::SUP_5V] = 1'b0;
	assign ign[hps_pkg::SUP_12V] = st_r.cmd_r[hps_pkg::CMD_IGN_POS12];
	assign ign[hps_pkg::SUP_NEG] = st_r.cmd_r[hps_pkg::CMD_IGN_NEG12];
	genvar gi;
	generate
		for (gi = 0; gi < hps_pkg::NSUP; gi++)
		begin : g_filt
			// current limit ignored during the ramp blanking
			assign oc_en[gi] = oc_s[gi] && (st_r.seq_r != hps_pkg::SEQ_RAMP
				|| tmr_s);
			hps_filt u_filt (
				.CLK(CLK),
				.RST_N(RST_N),
				.OC(oc_en[gi]),
				.CLR(clr_trip || ign[gi]),
				.TRIP(trip[gi])
			);
		end
	endgenerate

	// status byte layout
	assign status = {pc2_s, pc1_s, ~st_r.ok_r, st_r.lrst_r, rstin_s,
		st_r.code_r[1], st_r.code_r[0], st_r.fault_r};

	// address: fixed top bits plus one of two select values
	assign my_addr = {hps_pkg::ADDR_TOP,
		asel_s ? hps_pkg::ADDR_SEL_HIGH : hps_pkg::ADDR_SEL_LOW};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic scl_rise, scl_fall, start, stop, off_req, eff_fault;
		logic [3:0] tr_m;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		off_req = 1'b0;
		eff_fault = 1'b0;
		tr_m = '0;
		st_nxt = st_r;
		st_nxt.scl_d_r = scl_s;
		st_nxt.sda_d_r = sda_s;
		st_nxt.bsel_d_r = bsel_s;
		scl_rise = scl_s && !st_r.scl_d_r;
		scl_fall = !scl_s && st_r.scl_d_r;
		start = scl_s && st_r.scl_d_r && st_r.sda_d_r && !sda_s;
		stop = scl_s && st_r.scl_d_r && !st_r.sda_d_r && sda_s;

		// serial target: only send byte and receive byte
		if (start)
		begin
			st_nxt.i2c_r = I2C_ADDR;
			st_nxt.bit_r = '0;
			st_nxt.sda_oe_r = 1'b0;
		end
		else if (stop)
		begin
			st_nxt.i2c_r = I2C_IDLE;
			st_nxt.sda_oe_r = 1'b0;
		end
		else
		begin
			unique case (st_r.i2c_r)
				I2C_IDLE, I2C_SKIP:
					st_nxt.sda_oe_r = 1'b0;
				I2C_ADDR:
					if (scl_rise)
					begin
						st_nxt.sh_r = {st_r.sh_r[6:0], sda_s};
						st_nxt.bit_r = st_r.bit_r + 4'h1;
					end
					else if (scl_fall && st_r.bit_r == 4'h8)
					begin
						st_nxt.bit_r = '0;
						st_nxt.rw_r = st_r.sh_r[0];
						if (st_r.sh_r[7:1] == my_addr)
						begin
							st_nxt.i2c_r = I2C_AACK;
							st_nxt.sda_oe_r = 1'b1;
						end
						else
							st_nxt.i2c_r = I2C_SKIP;
					end
				I2C_AACK:
					if (scl_fall)
					begin
						st_nxt.sda_oe_r = 1'b0;
						if (st_r.rw_r)
						begin
							// sample pins at read start
							st_nxt.sh_r = status;
							st_nxt.sda_oe_r = !status[7];
							st_nxt.i2c_r = I2C_RDAT;
						end
						else
							st_nxt.i2c_r = I2C_WDAT;
					end
				I2C_WDAT:
					if (scl_rise)
					begin
						st_nxt.sh_r = {st_r.sh_r[6:0], sda_s};
						st_nxt.bit_r = st_r.bit_r + 4'h1;
					end
					else if (scl_fall && st_r.bit_r == 4'h8)
					begin
						st_nxt.i2c_r = I2C_DACK;
						st_nxt.sda_oe_r = 1'b1;
						// command takes effect at data acknowledge
						st_nxt.cmd_r = st_r.sh_r;
					end
				I2C_DACK:
					if (scl_fall)
					begin
						// further bytes are not acknowledged
						st_nxt.sda_oe_r = 1'b0;
						st_nxt.i2c_r = I2C_SKIP;
					end
				I2C_RDAT:
					if (scl_fall)
					begin
						if (st_r.bit_r == hps_pkg::BIT_LAST)
						begin
							st_nxt.sda_oe_r = 1'b0;
							st_nxt.i2c_r = I2C_RACK;
						end
						else
						begin
							st_nxt.sh_r = {st_r.sh_r[6:0], 1'b0};
							st_nxt.sda_oe_r = !st_r.sh_r[6];
							st_nxt.bit_r = st_r.bit_r + 4'h1;
						end
					end
				I2C_RACK:
					// single byte read only
					if (scl_fall)
						st_nxt.i2c_r = I2C_SKIP;
			endcase
		end

		// masked fault sources and priority code
		tr_m = trip;
		if (st_r.cmd_r[hps_pkg::CMD_IGN_POS12])
			tr_m[hps_pkg::SUP_12V] = 1'b0;
		if (st_r.cmd_r[hps_pkg::CMD_IGN_NEG12])
			tr_m[hps_pkg::SUP_NEG] = 1'b0;
		eff_fault = |tr_m;
		if (eff_fault && st_r.fault_r)
		begin
			st_nxt.fault_r = 1'b0;
			if (tr_m[hps_pkg::SUP_3V])
				st_nxt.code_r = hps_pkg::CODE_3V;
			else if (tr_m[hps_pkg::SUP_5V])
				st_nxt.code_r = hps_pkg::CODE_5V;
			else if (tr_m[hps_pkg::SUP_12V])
				st_nxt.code_r = hps_pkg::CODE_12V;
			else
				st_nxt.code_r = hps_pkg::CODE_NEG;
		end

		// power sequencer; all_off overrides select, serial abort at once
		off_req = bsel_s || st_r.cmd_r[hps_pkg::CMD_ALL_OFF];
		st_nxt.cyc_r = st_r.cmd_r[hps_pkg::CMD_ALL_OFF];
		unique case (st_r.seq_r)
			hps_pkg::SEQ_OFF:
				// falling select, or all_off released = power cycle;
				// no restart of its own after a fault
				if (!off_req && ((st_r.bsel_d_r && !bsel_s) ||
					st_r.cyc_r))
				begin
					st_nxt.seq_r = hps_pkg::SEQ_RAMP;
					st_nxt.fault_r = 1'b1;
				end
			hps_pkg::SEQ_RAMP, hps_pkg::SEQ_ON:
				if (off_req || eff_fault)
					st_nxt.seq_r = hps_pkg::SEQ_DOWN;
				else if (&good_s && tmr_s)
					st_nxt.seq_r = hps_pkg::SEQ_ON;
			hps_pkg::SEQ_DOWN:
				// complete once every output has collapsed
				if (good_s == 4'h0)
					st_nxt.seq_r = hps_pkg::SEQ_OFF;
		endcase

		// outputs
		st_nxt.ok_r = st_r.seq_r == hps_pkg::SEQ_ON && &good_s;
		st_nxt.lrst_r = st_nxt.ok_r && rstin_s &&
			!st_r.cmd_r[hps_pkg::CMD_RST_ASSERT];
		st_nxt.led_r = st_r.cmd_r[hps_pkg::CMD_LED_ON] ||
			st_r.seq_r == hps_pkg::SEQ_OFF;
	end

	// ----------------------------------------------------------------
	// registers; power arrival resets the latch
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			// edge history matches the synchronisers' zero reset,
			// so no false select fall or start follows reset
			st_r <= '0;
			st_r.fault_r <= 1'b1;
			st_r.led_r <= 1'b1;
			st_r.cmd_r <= hps_pkg::CMD_RESET;
		end
		else
			st_r <= st_nxt;
	end

	// switches only close while ramping or on
	assign SWITCH_ON = {hps_pkg::NSUP{st_r.seq_r == hps_pkg::SEQ_RAMP ||
		st_r.seq_r == hps_pkg::SEQ_ON}};
	assign SDA_OUT = 1'b0;
	assign SDA_OE = st_r.sda_oe_r;
	assign LOCAL_RST_PIN_N = st_r.lrst_r;
	assign STATUS_LED = st_r.led_r;
	assign BOARD_OK_N = ~st_r.ok_r;
	assign FAULT_N = st_r.fault_r;
	assign SUPPLY_CODE_BIT0 = st_r.code_r[0];
	assign SUPPLY_CODE_BIT1 = st_r.code_r[1];
endmodule : hps_top

// ==== hps_monitor.sv ====
`timescale 1ns/1ns
// port checks of the sequencer
module hps_monitor (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic SCL,
	input wire logic SDA_OE,
	input wire logic BOARD_SELECT_N,
	input wire logic INCOMING_RST_PIN,
	input wire logic [3:0] SUPPLY_GOOD,
	input wire logic [3:0] OVER_CURRENT,
	input wire logic TIMER_DONE,
	input wire logic [3:0] SWITCH_ON,
	input wire logic LOCAL_RST_PIN_N,
	input wire logic STATUS_LED,
	input wire logic BOARD_OK_N,
	input wire logic FAULT_N
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	logic [11:0] oc_r;

	// overcurrent run length; saturates so it never wraps
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			oc_r <= 12'h0;
		else
			oc_r <= (|OVER_CURRENT) ? oc_r + 12'(oc_r != 12'hFFF) : 12'h0;

	// 12'hDAC is the 3500 cycle filter
	AST_TRIP: assert property ($fell(FAULT_N) |-> oc_r >= 12'hDAC)
		else $error("fault before filter time");
	AST_BLANK: assert property (!TIMER_DONE [*5] |-> !$fell(FAULT_N))
		else $error("fault while blanked");
	AST_OK_GOOD: assert property
		($fell(BOARD_OK_N) |-> $past(SUPPLY_GOOD, 2) == 4'hF)
		else $error("board_ok_n before supplies good");
	AST_OK_SW: assert property
		($fell(BOARD_OK_N) |-> SWITCH_ON == 4'hF)
		else $error("board_ok_n with switches off");
	AST_SW_ALL: assert property
		(SWITCH_ON == 4'h0 || SWITCH_ON == 4'hF)
		else $error("switches split");
	AST_SEL_OFF: assert property
		(BOARD_SELECT_N [*5] |-> SWITCH_ON == 4'h0)
		else $error("switch on with select high");
	AST_FOLLOW: assert property
		((!INCOMING_RST_PIN && !BOARD_OK_N) [*5] |-> !LOCAL_RST_PIN_N)
		else $error("local reset not following");
	AST_OFF_RST: assert property
		((SWITCH_ON == 4'h0 && SUPPLY_GOOD == 4'h0) [*3] |-> !LOCAL_RST_PIN_N)
		else $error("local reset released while off");
	AST_OFF_LED: assert property
		((SWITCH_ON == 4'h0 && SUPPLY_GOOD == 4'h0) [*6] |-> STATUS_LED)
		else $error("led dark while off");
	AST_ACK_LOW: assert property ($rose(SDA_OE) |-> !SCL)
		else $error("data driven with clock high");

	// main scenarios
	cover property (!BOARD_OK_N);
	cover property ($fell(FAULT_N));
	cover property ($rose(SDA_OE));
endmodule : hps_monitor

bind hps_top hps_monitor u_hps_monitor (
	.CLK(CLK), .RST_N(RST_N), .SCL(SCL), .SDA_OE(SDA_OE),
	.BOARD_SELECT_N(BOARD_SELECT_N), .INCOMING_RST_PIN(INCOMING_RST_PIN),
	.SUPPLY_GOOD(SUPPLY_GOOD), .OVER_CURRENT(OVER_CURRENT),
	.TIMER_DONE(TIMER_DONE), .SWITCH_ON(SWITCH_ON),
	.LOCAL_RST_PIN_N(LOCAL_RST_PIN_N), .STATUS_LED(STATUS_LED),
	.BOARD_OK_N(BOARD_OK_N), .FAULT_N(FAULT_N)
);

// ==== hps_host.sv ====
`timescale 1ns/1ns
// serial host; clock runs only within frames, data is open drain
module hps_host (
	output logic scl,
	output logic sda_low,
	input wire logic sda,
	output logic [7:0] rd_val,
	output int rd_cnt
);
	localparam int Q = 31; // quarter of a 124 ns bit

	// idle: clock driven high, data left to its pull-up
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
		rd_val = 8'h00;
	end

	// one bit; data moves only while the clock is low
	task bit_x(input logic b, output logic s);
		scl = 1'b0;
		#Q sda_low = !b;
		#Q scl = 1'b1;
		#Q s = sda;
		#Q scl = 1'b0;
	endtask : bit_x

	// byte then ninth bit, giving acknowledge
	task put(input logic [7:0] d, output logic k);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], s);
		bit_x(1'b1, s);
		k = !s;
	endtask : put

	// start: data falls with clock high
	task go();
		sda_low = 1'b0;
		scl = 1'b1;
		#Q sda_low = 1'b1;
		#Q;
	endtask : go

	// stop, then idle gap
	task halt();
		#Q sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#(4 * Q);
	endtask : halt

	// send byte frame
	task wr(input logic [6:0] a, input logic [7:0] d, output logic [1:0] k);
		go();
		put({a, 1'b0}, k[1]);
		put(d, k[0]);
		halt();
	endtask : wr

	// receive byte frame, ended by a NACK
	task rd(input logic [6:0] a, output logic k);
		logic [7:0] v;
		logic s;
		go();
		put({a, 1'b1}, k);
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, v[i]);
		bit_x(1'b1, s);
		halt();
		rd_val = v;
		rd_cnt++;
	endtask : rd
endmodule : hps_host

// ==== hps_top_tb_top.sv ====
`timescale 1ns/1ns
module hps_top_tb_top;
	logic clk, rst_n, asel, sel_n, inc_n, p1_n, p2_n, tmr, a1;
	logic sda_out, sda_oe, lrst_n, led, ok_n, flt_n, cb0, cb1, scl, low;
	logic [3:0] good, oc, sw;
	logic [1:0] ack;
	logic [6:0] dev;
	logic [7:0] rd_val;
	logic [15:0] e;
	logic [15:0] exp_q[$];
	int rd_cnt, errors, total_checks;
	string nm[6] = '{"switch", "ok", "lrst", "fault", "led", "code"};
	wire sda = !(low || (sda_oe && !sda_out));

	hps_top u_hps_top (.CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SEL(asel),
		.BOARD_SELECT_N(sel_n), .INCOMING_RST_PIN(inc_n),
		.BOARD_POWER_CODE1_N(p1_n), .BOARD_POWER_CODE2_N(p2_n),
		.SUPPLY_GOOD(good), .OVER_CURRENT(oc), .TIMER_DONE(tmr),
		.SWITCH_ON(sw), .LOCAL_RST_PIN_N(lrst_n), .STATUS_LED(led),
		.BOARD_OK_N(ok_n), .FAULT_N(flt_n), .SUPPLY_CODE_BIT0(cb0),
		.SUPPLY_CODE_BIT1(cb1));
	hps_host u_hps_host (.scl(scl), .sda_low(low), .sda(sda),
		.rd_val(rd_val), .rd_cnt(rd_cnt));

	// 100 MHz
	initial
	begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end

	task complete_run();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task cmp8(input string n, input logic [7:0] x, input logic [7:0] g);
		total_checks++;
		if (g !== x)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask : cmp8

	function automatic logic [3:0] pick(input int s);
		case (s)
			0: pick = sw;
			1: pick = {3'h0, ok_n};
			2: pick = {3'h0, lrst_n};
			3: pick = {3'h0, flt_n};
			4: pick = {3'h0, led};
			default: pick = {2'h0, cb1, cb0};
		endcase
	endfunction : pick

	// bounded wait for an output, sampled on the quiet edge
	task await(input int s, input logic [3:0] v);
		int k;
		k = 0;
		@(negedge clk);
		while (pick(s) !== v && k < 50)
		begin
			@(negedge clk);
			k++;
		end
		cmp8(nm[s], {4'h0, v}, {4'h0, pick(s)});
		if (k == 50)
			complete_run();
	endtask : await

	task cmd(input logic [7:0] d);
		u_hps_host.wr(dev, d, ack);
		cmp8("wr ack", 8'h03, {6'h0, ack});
	endtask : cmd

	// note masked expectation, then read
	task status(input logic [7:0] x, input logic [7:0] m);
		exp_q.push_back({m, x & m});
		u_hps_host.rd(dev, a1);
		cmp8("rd ack", 8'h01, {7'h0, a1});
	endtask : status

	// each read against the oldest note
	always @(rd_cnt)
	begin
		e = exp_q.pop_front();
		cmp8("status", e[7:0], rd_val & e[15:8]);
	end

	initial
	begin
		rst_n = 1'b0;
		asel = 1'b0;
		sel_n = 1'b1;
		inc_n = 1'b1;
		tmr = 1'b0;
		good = 4'h0;
		oc = 4'h0;
		dev = 7'h68;
		void'($urandom(32'h73A2));
		p1_n = 1'($urandom);
		p2_n = 1'($urandom);
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		await(4, 4'h1);
		await(2, 4'h0);
		status({p2_n, p1_n, 6'h29}, 8'hF9);
		@(posedge clk);
		sel_n <= 1'b0;
		await(0, 4'hF);
		@(posedge clk);
		good <= 4'h7;
		oc <= 4'h1;
		repeat (3600) @(posedge clk);
		await(3, 4'h1);
		@(posedge clk);
		oc <= 4'h0;
		tmr <= 1'b1;
		repeat (20) @(posedge clk);
		await(1, 4'h1);
		good <= 4'hF;
		await(1, 4'h0);
		@(posedge clk);
		inc_n <= 1'b0;
		await(2, 4'h0);
		@(posedge clk);
		inc_n <= 1'b1;
		await(2, 4'h1);
		cmd(8'h08);
		await(2, 4'h0);
		cmd(8'h02);
		await(4, 4'h1);
		await(2, 4'h1);
		status({p2_n, p1_n, 6'h19}, 8'hF9);
		u_hps_host.wr(7'h55, 8'h00, ack);
		cmp8("foreign", 8'h00, {6'h0, ack});
		@(posedge clk);
		asel <= 1'b1;
		u_hps_host.wr(7'h68, 8'h00, ack);
		cmp8("foreign", 8'h00, {6'h0, ack});
		dev = 7'h77;
		cmd(8'h10);
		@(posedge clk);
		oc <= 4'h4;
		repeat (3600) @(posedge clk);
		await(3, 4'h1);
		@(posedge clk);
		oc <= 4'h0;
		cmd(8'h00);
		@(posedge clk);
		oc <= 4'h2;
		repeat (3400) @(posedge clk);
		await(3, 4'h1);
		repeat (150) @(posedge clk);
		await(3, 4'h0);
		await(5, 4'h2);
		status({p2_n, p1_n, 6'h0C}, 8'hCF);
		@(posedge clk);
		oc <= 4'h0;
		good <= 4'h0;
		await(4, 4'h1);
		cmd(8'h04);
		await(0, 4'h0);
		cmd(8'h00);
		await(0, 4'hF);
		cmd(8'h04);
		await(0, 4'h0);
		cmd(8'h00);
		await(0, 4'hF);
		@(posedge clk);
		sel_n <= 1'b1;
		await(0, 4'h0);
		cmp8("pending", 8'h00, 8'(exp_q.size()));
		complete_run();
	end
endmodule : hps_top_tb_top
